// [verilog/gio_regs.svh]
// gio_regs.svh: register indices and reset values of the pin port
// assumes: included by bare name from the package and the port module
`ifndef GIO_REGS_SVH
`define GIO_REGS_SVH

`define GIO_IDX_LEVEL      3'h0
`define GIO_IDX_INT_EN     3'h1
`define GIO_IDX_THREE_ST   3'h2
`define GIO_IDX_POLARITY   3'h3
`define GIO_IDX_DIR_SEL    3'h4
`define GIO_IDX_PENDING    3'h5

`define GIO_RST_LEVEL      8'h00
`define GIO_RST_INT_EN     8'h00
`define GIO_RST_THREE_ST   8'h00
`define GIO_RST_POLARITY   8'h00
`define GIO_RST_DIR_SEL    8'hFF
`define GIO_RST_PENDING    8'h00

`endif

// [verilog/gio_pkg.sv]
// gio_pkg.sv: types shared by the pin port files
// assumes: gio_regs.svh on the include path
`include "gio_regs.svh"

package gio_pkg;

  typedef logic [2:0] gio_idx_t;

  // one register access from the device's host interface
  typedef struct packed {
    logic     rd;
    logic     wr;
    gio_idx_t idx;
    logic [7:0] wdata;
  } gio_reg_req_t;

  // registered answer to a read
  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } gio_reg_rsp_t;

endpackage : gio_pkg

// [verilog/gio_pin_sync.sv]
// gio_pin_sync.sv: two-stage synchroniser and edge detect for pin inputs
// assumes: pins are asynchronous to clk_i; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none

module gio_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // meta_q is read only by sync_q
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;

endmodule : gio_pin_sync

`default_nettype wire

// [verilog/gio_port.sv]
// gio_port.sv: general-purpose pin port with per-pin edge interrupts
// assumes: register access port driven by host logic on clk_i; pins are
// external and asynchronous; the pad combines out/oe into the wire level
`timescale 1ns/1ps
`default_nettype none
`include "gio_regs.svh"

module gio_port #(
  parameter int NPINS = 8
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire gio_pkg::gio_reg_req_t req_i,
  output gio_pkg::gio_reg_rsp_t     rsp_o,
  input  wire logic [NPINS-1:0]     pin_i,
  output logic      [NPINS-1:0]     pin_o,
  output logic      [NPINS-1:0]     pin_oe_o,
  output logic                      irq_n_o
);

  if (NPINS < 1 || NPINS > 8)
  begin : g_bad_width
    $error("gio_port: NPINS must lie between 1 and 8");
  end

  logic [NPINS-1:0] level_q;
  logic [NPINS-1:0] int_en_q;
  logic [NPINS-1:0] three_st_q;
  logic [NPINS-1:0] polarity_q;
  logic [NPINS-1:0] dir_sel_q;
  logic [NPINS-1:0] pending_q;
  logic [NPINS-1:0] pending_d;
  logic             rsp_valid_q;
  logic [7:0]       rsp_data_q;
  logic             irq_n_q;
  logic [NPINS-1:0] pin_out_q;
  logic [NPINS-1:0] pin_oe_q;

  logic [NPINS-1:0] pin_lvl;
  logic [NPINS-1:0] pin_rise;
  logic [NPINS-1:0] pin_fall;
  logic [NPINS-1:0] pin_event;
  logic [NPINS-1:0] clr_mask;
  logic [NPINS-1:0] level_rd;
  logic [7:0]       rd_mux;

  gio_pin_sync #(
    .WIDTH (NPINS)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (pin_i),
    .level_o (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  // write strobe decode for one register index
  function automatic logic wr_hit(input gio_pkg::gio_reg_req_t r,
                                  input gio_pkg::gio_idx_t     idx);
    wr_hit = r.wr && (r.idx == idx);
  endfunction : wr_hit

  // narrow the 8-bit write data to the pin count
  function automatic logic [NPINS-1:0] wbits(input logic [7:0] d);
    wbits = d[NPINS-1:0];
  endfunction : wbits

  // widen pin-count data to the 8-bit read bus, upper bits zero
  function automatic logic [7:0] rbits(input logic [NPINS-1:0] d);
    logic [7:0] r;
    r = 8'h00;
    r[NPINS-1:0] = d;
    rbits = r;
  endfunction : rbits

  // output level register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      level_q <= NPINS'(`GIO_RST_LEVEL);
    else if (wr_hit(req_i, `GIO_IDX_LEVEL))
      level_q <= wbits(req_i.wdata);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      int_en_q <= NPINS'(`GIO_RST_INT_EN);
    else if (wr_hit(req_i, `GIO_IDX_INT_EN))
      int_en_q <= wbits(req_i.wdata);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      three_st_q <= NPINS'(`GIO_RST_THREE_ST);
    else if (wr_hit(req_i, `GIO_IDX_THREE_ST))
      three_st_q <= wbits(req_i.wdata);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      polarity_q <= NPINS'(`GIO_RST_POLARITY);
    else if (wr_hit(req_i, `GIO_IDX_POLARITY))
      polarity_q <= wbits(req_i.wdata);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dir_sel_q <= NPINS'(`GIO_RST_DIR_SEL);
    else if (wr_hit(req_i, `GIO_IDX_DIR_SEL))
      dir_sel_q <= wbits(req_i.wdata);
  end

  // pad drive: registered so the pins change one cycle after a write,
  // and so an input pin never glitches while the registers settle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pin_out_q <= '0;
    else
      pin_out_q <= level_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pin_oe_q <= '0;
    else
      pin_oe_q <= ~dir_sel_q & ~three_st_q;
  end

  // per-pin event: chosen edge on an enabled input pin
  genvar g;
  for (g = 0; g < NPINS; g++)
  begin : g_event
    assign pin_event[g] = dir_sel_q[g] && int_en_q[g] &&
                          (polarity_q[g] ? pin_fall[g]
                                         : pin_rise[g]);
  end

  // level read: output pins report their wire state too, inverted where polarity_q is set
  for (g = 0; g < NPINS; g++)
  begin : g_level_rd
    assign level_rd[g] = polarity_q[g] ? ~pin_lvl[g]
                                       : pin_lvl[g];
  end

  // write-one-to-clear; a new event in the same cycle keeps its bit
  assign clr_mask = wr_hit(req_i, `GIO_IDX_PENDING) ?
                    wbits(req_i.wdata) : '0;

  always_comb
  begin
    pending_d = (pending_q & ~clr_mask) | pin_event;
    // a pin whose enable or direction is dropped can no longer interrupt
    pending_d = pending_d & int_en_q & dir_sel_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pending_q <= NPINS'(`GIO_RST_PENDING);
    else
      pending_q <= pending_d;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_n_q <= 1'b1;
    else
      irq_n_q <= ~(|pending_d);
  end

  // read mux; unmapped indices read as zero
  always_comb
  begin
    unique case (req_i.idx)
      `GIO_IDX_LEVEL:    rd_mux = rbits(level_rd);
      `GIO_IDX_INT_EN:   rd_mux = rbits(int_en_q);
      `GIO_IDX_THREE_ST: rd_mux = rbits(three_st_q);
      `GIO_IDX_POLARITY: rd_mux = rbits(polarity_q);
      `GIO_IDX_DIR_SEL:  rd_mux = rbits(dir_sel_q);
      `GIO_IDX_PENDING:  rd_mux = rbits(pending_q);
      default:           rd_mux = 8'h00;
    endcase
  end

  // answer valid for exactly one cycle after a read
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rsp_valid_q <= 1'b0;
    else
      rsp_valid_q <= req_i.rd;
  end

  // read data holds until the next read answer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rsp_data_q <= 8'h00;
    else if (req_i.rd)
      rsp_data_q <= rd_mux;
  end

  assign rsp_o    = '{valid: rsp_valid_q, rdata: rsp_data_q};
  assign pin_o    = pin_out_q;
  assign pin_oe_o = pin_oe_q;
  assign irq_n_o  = irq_n_q;

endmodule : gio_port

`default_nettype wire

// [tb/gio_port_checker.sv]
// gio_port_checker.sv: assertions on the pin port's ports
// assumes: bound into gio_port; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module gio_port_checker #(
  parameter int NPINS = 8
) (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire gio_pkg::gio_reg_req_t req_i,
  input wire gio_pkg::gio_reg_rsp_t rsp_o,
  input wire logic [NPINS-1:0]      pin_i,
  input wire logic [NPINS-1:0]      pin_o,
  input wire logic [NPINS-1:0]      pin_oe_o,
  input wire logic                  irq_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_dir_input:
  assert property (req_i.wr && req_i.idx == 3'h4 && req_i.wdata == 8'hFF
    ##1 !(req_i.wr && req_i.idx == 3'h4) |=> pin_oe_o == '0)
    else $error("input pin driven");
  chk_tri_float:
  assert property (req_i.wr && req_i.idx == 3'h2 && req_i.wdata == 8'hFF
    ##1 !(req_i.wr && req_i.idx == 3'h2) |=> pin_oe_o == '0)
    else $error("three-stated pin driven");
  chk_en_drop:
  assert property (req_i.wr && req_i.idx == 3'h1 && req_i.wdata == 8'h00
    ##1 !(req_i.wr && req_i.idx == 3'h1) |=> irq_n_o)
    else $error("interrupt kept after disable");
  chk_irq_cause:
  assert property ($fell(irq_n_o) |-> $past(pin_i, 3) != $past(pin_i, 4))
    else $error("interrupt without pin change");
  chk_read_answer:
  assert property (req_i.rd |=> rsp_o.valid ##1
    (rsp_o.valid == $past(req_i.rd))) else $error("read answer timing");
  chk_reset_idle:
  assert property ($rose(rst_n_i) |-> irq_n_o && pin_oe_o == '0)
    else $error("outputs active after reset");
endmodule : gio_port_checker
bind gio_port gio_port_checker #(.NPINS(NPINS)) u_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .req_i(req_i), .rsp_o(rsp_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o), .irq_n_o(irq_n_o));
`default_nettype wire

// [tb/gio_board.sv]
// gio_board.sv: board-side model of the pin wires
// assumes: no pulls; board drives only pins the port leaves free
`timescale 1ns/1ps
`default_nettype none
module gio_board (
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  output logic      [7:0] wire_o
);
  // a driven pin reads back the port's own value
  assign wire_o = (out_i & oe_i) | (drv_i & ~oe_i);
endmodule : gio_board
`default_nettype wire

// [tb/tb_gio_port_with_edge_interrupts.sv]
// tb_gio_port_with_edge_interrupts.sv: self-checking bench of the port
// assumes: gio_port, gio_board and the checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_gio_port_with_edge_interrupts;
  logic                  clk_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  gio_pkg::gio_reg_req_t req = '0;
  gio_pkg::gio_reg_rsp_t rsp;
  logic [7:0]            drv = 8'h00, pin, pout, poe;
  logic                  irq_n;
  int                    fail_count = 0, n_tests = 0;
  always #25 clk_i = ~clk_i;
  gio_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .rsp_o(rsp), .pin_i(pin), .pin_o(pout), .pin_oe_o(poe),
    .irq_n_o(irq_n));
  gio_board board (.drv_i(drv), .out_i(pout), .oe_i(poe), .wire_o(pin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_i);
    #2 req = '{!w, w, i, d};
    @(posedge clk_i);
    #2 req = '0;
  endtask : acc
  task automatic rd(input logic [2:0] i, input logic [7:0] exp);
    acc(1'b0, i, 8'h00);
    chk({7'h00, rsp.valid}, 8'h01);
    chk(rsp.rdata, exp);
  endtask : rd
  // irq lands two edges after the pin is first sampled
  task automatic pins(input logic [7:0] d);
    @(posedge clk_i);
    #2 drv = d;
    repeat (4) @(posedge clk_i);
    #2;
  endtask : pins
  task automatic t_reset;
    logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) rd(i[2:0], rv[i]);
    chk(poe, 8'h00);
  endtask : t_reset
  task automatic t_drive;
    acc(1'b1, 3'h4, 8'hF0);
    acc(1'b1, 3'h2, 8'h03);
    acc(1'b1, 3'h0, 8'hA5);
    repeat (2) @(posedge clk_i);
    #2 chk(poe, 8'h0C);
    chk(pout, 8'hA5);
    acc(1'b1, 3'h2, 8'hFF);
    repeat (2) @(posedge clk_i);
    #2 chk(poe, 8'h00);
    acc(1'b1, 3'h2, 8'h00);
    repeat (2) @(posedge clk_i);
    #2 chk(poe, 8'h0F);
    rd(3'h0, 8'h05);
    acc(1'b1, 3'h4, 8'hFF);
    repeat (2) @(posedge clk_i);
    #2 chk(poe, 8'h00);
  endtask : t_drive
  task automatic t_rise;
    acc(1'b1, 3'h1, 8'h01);
    pins(8'h01);
    chk({7'h00, irq_n}, 8'h00);
    rd(3'h0, 8'h01);
    rd(3'h5, 8'h01);
    acc(1'b1, 3'h5, 8'h01);
    @(posedge clk_i);
    #2 chk({7'h00, irq_n}, 8'h01);
    pins(8'h03);
    chk({7'h00, irq_n}, 8'h01);
  endtask : t_rise
  task automatic t_fall;
    acc(1'b1, 3'h3, 8'h01);
    rd(3'h0, 8'h02);
    pins(8'h02);
    chk({7'h00, irq_n}, 8'h00);
    acc(1'b1, 3'h1, 8'h00);
    @(posedge clk_i);
    #2 chk({7'h00, irq_n}, 8'h01);
  endtask : t_fall
  task automatic t_rerst;
    @(posedge clk_i);
    #2 rst_n_i = 1'b0;
    @(posedge clk_i);
    #2 rst_n_i = 1'b1;
    rd(3'h4, 8'hFF);
    rd(3'h3, 8'h00);
  endtask : t_rerst
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (6) @(posedge clk_i);
    #2 rst_n_i = 1'b1;
    t_reset();
    t_drive();
    t_rise();
    t_fall();
    t_rerst();
    wrap_up();
  end
  initial
  begin
    #100000;
    fail_count++;
    wrap_up();
  end
endmodule : tb_gio_port_with_edge_interrupts
`default_nettype wire
